// ---- verilog/alsc_top.sv ----
// light sensor controller: serial slave, registers, alarm pin
`timescale 1ns/100ps
module alsc_top
  import alsc_pkg::*;
#(
  parameter int CYC16 = CONV_CYC
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic int_o,
  output logic int_oe_n_o,
  input wire logic [15:0] adc_sample_i,
  output logic [1:0] range_o,
  output logic sensor_pwr_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR_RX,
    I2C_ADDR_ACK,
    I2C_WR,
    I2C_WR_ACK,
    I2C_RD,
    I2C_RD_ACK
  } alsc_i2c_e;

  typedef struct packed {
    alsc_i2c_e ph;
    logic scl_q;
    logic sda_q;
    logic [2:0] bitc;
    logic full;
    logic [7:0] shr;
    logic [7:0] ptr;
    logic rw;
    logic first;
    logic sda_oe_n;
    alsc_cfg_s cfg;
    logic flag;
    logic [15:0] thr;
    logic start;
    logic int_oe_n;
  } alsc_top_s;

  alsc_top_s st_ff;
  alsc_top_s nxt_st;
  logic conv_done;
  logic [15:0] conv_data;

  // register read view
  function automatic logic [7:0] rd_val(input alsc_top_s s,
                                        input logic [15:0] d,
                                        input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == REG_CMD) begin
      v[CMD_FLAG_BIT] = s.flag;
      v[CMD_MODE_LSB +: 2] = s.cfg.mode;
    end else if (a == REG_CTRL) begin
      v[CTRL_RANGE_LSB +: 2] = s.cfg.range;
      v[CTRL_RES_LSB +: 2] = s.cfg.res;
    end else if (a == REG_DATA_LSB) begin
      v = d[7:0];
    end else if (a == REG_DATA_MSB) begin
      v = d[15:8];
    end else if (a == REG_THR_LSB) begin
      v = s.thr[7:0];
    end else if (a == REG_THR_MSB) begin
      v = s.thr[15:8];
    end
    return v;
  endfunction : rd_val

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  alsc_conv #(
    .CYC16(CYC16)
  ) u_conv (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .cfg_i(st_ff.cfg),
    .start_i(st_ff.start),
    .sample_i(adc_sample_i),
    .done_o(conv_done),
    .data_o(conv_data),
    .pwr_o(sensor_pwr_o)
  );

  // ---------------------------------------------------------------
  // serial slave and registers
  // ---------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic clr;
    logic [7:0] wd;
    rise = 1'b0;
    fall = 1'b0;
    clr = 1'b0;
    wd = 8'h00;
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    nxt_st.scl_q = scl_i;
    nxt_st.sda_q = sda_i;
    rise = scl_i & ~st_ff.scl_q;
    fall = ~scl_i & st_ff.scl_q;
    if (scl_i && st_ff.scl_q && st_ff.sda_q && !sda_i) begin
      nxt_st.ph = I2C_ADDR_RX;
      nxt_st.bitc = 3'h0;
      nxt_st.full = 1'b0;
      nxt_st.sda_oe_n = 1'b1;
    end else if (scl_i && st_ff.scl_q && !st_ff.sda_q && sda_i) begin
      nxt_st.ph = I2C_IDLE;
      nxt_st.sda_oe_n = 1'b1;
    end else if (rise) begin
      case (st_ff.ph)
        I2C_ADDR_RX, I2C_WR: begin
          nxt_st.shr = {st_ff.shr[6:0], sda_i};
          nxt_st.bitc = st_ff.bitc + 3'h1;
          nxt_st.full = (st_ff.bitc == 3'h7);
        end
        I2C_RD_ACK: begin
          if (sda_i) begin
            nxt_st.ph = I2C_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      case (st_ff.ph)
        I2C_ADDR_RX: begin
          if (st_ff.full) begin
            nxt_st.full = 1'b0;
            if (st_ff.shr[7:1] == I2C_ADDR) begin
              nxt_st.sda_oe_n = 1'b0;
              nxt_st.rw = st_ff.shr[0];
              nxt_st.ph = I2C_ADDR_ACK;
            end else begin
              nxt_st.ph = I2C_IDLE;
            end
          end
        end
        I2C_ADDR_ACK, I2C_RD_ACK: begin
          if (st_ff.ph == I2C_RD_ACK || st_ff.rw) begin
            wd = rd_val(st_ff, conv_data, st_ff.ptr);
            nxt_st.shr = wd;
            nxt_st.sda_oe_n = wd[7];
            nxt_st.ptr = st_ff.ptr + 8'h01;
            nxt_st.bitc = 3'h0;
            nxt_st.ph = I2C_RD;
          end else begin
            nxt_st.sda_oe_n = 1'b1;
            nxt_st.first = 1'b1;
            nxt_st.ph = I2C_WR;
          end
        end
        I2C_WR: begin
          if (st_ff.full) begin
            nxt_st.full = 1'b0;
            nxt_st.sda_oe_n = 1'b0;
            nxt_st.ph = I2C_WR_ACK;
            wd = st_ff.shr;
            if (st_ff.first) begin
              nxt_st.first = 1'b0;
              nxt_st.ptr = wd;
            end else begin
              nxt_st.ptr = st_ff.ptr + 8'h01;
              if (st_ff.ptr == REG_CMD) begin
                nxt_st.cfg.mode = (wd[CMD_MODE_LSB +: 2] == 2'h3) ?
                  ALSC_PD : alsc_mode_e'(wd[CMD_MODE_LSB +: 2]);
                nxt_st.start =
                  (wd[CMD_MODE_LSB +: 2] == ALSC_ONESHOT);
                clr = ~wd[CMD_FLAG_BIT];
              end else if (st_ff.ptr == REG_CTRL) begin
                nxt_st.cfg.range = wd[CTRL_RANGE_LSB +: 2];
                nxt_st.cfg.res = wd[CTRL_RES_LSB +: 2];
              end else if (st_ff.ptr == REG_THR_LSB) begin
                nxt_st.thr[7:0] = wd;
              end else if (st_ff.ptr == REG_THR_MSB) begin
                nxt_st.thr[15:8] = wd;
              end
            end
          end
        end
        I2C_WR_ACK: begin
          nxt_st.sda_oe_n = 1'b1;
          nxt_st.ph = I2C_WR;
        end
        I2C_RD: begin
          if (st_ff.bitc == 3'h7) begin
            nxt_st.sda_oe_n = 1'b1;
            nxt_st.ph = I2C_RD_ACK;
          end else begin
            nxt_st.sda_oe_n = st_ff.shr[6];
            nxt_st.shr = {st_ff.shr[6:0], 1'b0};
            nxt_st.bitc = st_ff.bitc + 3'h1;
          end
        end
        default: begin
        end
      endcase
    end
    // set wins over a clear in the same cycle
    nxt_st.flag = (conv_done && conv_data > st_ff.thr) ||
                  (st_ff.flag && !clr);
    nxt_st.int_oe_n = ~nxt_st.flag;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
      st_ff.ph <= I2C_IDLE;
      st_ff.scl_q <= 1'b1;
      st_ff.sda_q <= 1'b1;
      st_ff.sda_oe_n <= 1'b1;
      st_ff.cfg.mode <= ALSC_PD;
      st_ff.cfg.range <= RANGE_RST;
      st_ff.cfg.res <= RES_RST;
      st_ff.thr <= THR_RST;
      st_ff.int_oe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  assign sda_o = 1'b0;
  assign sda_oe_n_o = st_ff.sda_oe_n;
  assign int_o = 1'b0;
  assign int_oe_n_o = st_ff.int_oe_n;
  assign range_o = st_ff.cfg.range;
endmodule : alsc_top

// ---- include/alsc_pkg.sv ----
// constants and types shared by the light sensor controller
package alsc_pkg;
  // ---------------------------------------------------------------
  // bus address and register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] I2C_ADDR = 7'h44;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h01;
  localparam logic [7:0] REG_DATA_LSB = 8'h02;
  localparam logic [7:0] REG_DATA_MSB = 8'h03;
  localparam logic [7:0] REG_THR_LSB = 8'h04;
  localparam logic [7:0] REG_THR_MSB = 8'h05;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CMD_MODE_LSB = 0;
  localparam int CMD_FLAG_BIT = 2;
  localparam int CTRL_RANGE_LSB = 0;
  localparam int CTRL_RES_LSB = 2;
  localparam logic [1:0] RANGE_RST = 2'h0;
  localparam logic [1:0] RES_RST = 2'h0;
  localparam logic [15:0] THR_RST = 16'hffff;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CONV_T_MS = 90;
  localparam int CONV_CYC = CONV_T_MS * (CLK_HZ / 1000);
  localparam int MIN_T_US = 11;
  localparam int MIN_CYC = (MIN_T_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int CNT_W = 21;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ALSC_PD,
    ALSC_ONESHOT,
    ALSC_CONT
  } alsc_mode_e;
  typedef struct packed {
    alsc_mode_e mode;
    logic [1:0] range;
    logic [1:0] res;
  } alsc_cfg_s;
endpackage : alsc_pkg

// ---- verilog/alsc_conv.sv ----
// conversion sequencer: timing, resolution and sensor power
`timescale 1ns/100ps
module alsc_conv
  import alsc_pkg::*;
#(
  parameter int CYC16 = CONV_CYC
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire alsc_cfg_s cfg_i,
  input wire logic start_i,
  input wire logic [15:0] sample_i,
  output logic done_o,
  output logic [15:0] data_o,
  output logic pwr_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic [CNT_W-1:0] cnt;
    logic [15:0] data;
    logic done;
    logic pwr;
  } alsc_conv_s;

  alsc_conv_s st_ff;
  alsc_conv_s nxt_st;

  if (CYC16 < MIN_CYC || CYC16 >= (1 << CNT_W)) begin : g_len_chk
    $error("alsc_conv: CYC16 out of range");
  end

  // conversion length shrinks 16x per resolution step, floored at MIN_CYC
  function automatic logic [CNT_W-1:0] conv_len(input logic [1:0] res);
    int l;
    l = CYC16 >> (4 * int'(res));
    if (l < MIN_CYC) begin
      l = MIN_CYC;
    end
    return l[CNT_W-1:0];
  endfunction : conv_len

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (cfg_i.mode != ALSC_ONESHOT && cfg_i.mode != ALSC_CONT) begin
      nxt_st.run = 1'b0;
      nxt_st.pwr = 1'b0;
    end else if (st_ff.run) begin
      if (st_ff.cnt == conv_len(cfg_i.res) - 1'b1) begin
        nxt_st.data = sample_i >> (4 * int'(cfg_i.res));
        nxt_st.done = 1'b1;
        nxt_st.cnt = '0;
        nxt_st.run = (cfg_i.mode == ALSC_CONT);
        nxt_st.pwr = (cfg_i.mode == ALSC_CONT);
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end else if (cfg_i.mode == ALSC_CONT || start_i) begin
      nxt_st.run = 1'b1;
      nxt_st.pwr = 1'b1;
      nxt_st.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done_o = st_ff.done;
  assign data_o = st_ff.data;
  assign pwr_o = st_ff.pwr;
endmodule : alsc_conv

// ---- testbench/alsc_monitor.sv ----
// port checker for the light sensor controller
`timescale 1ns/100ps
module alsc_monitor
  import alsc_pkg::*;
#(
  parameter int CYC16 = CONV_CYC
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic int_o,
  input wire logic int_oe_n_o,
  input wire logic [15:0] adc_sample_i,
  input wire logic [1:0] range_o,
  input wire logic sensor_pwr_o
);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  alarm_value_a: assert property (int_o == 1'b0)
    else $error("alarm pin value not low");
  data_value_a: assert property (sda_o == 1'b0)
    else $error("data pin value not low");
  flag_hold_a: assert property ($rose(int_oe_n_o) |-> !scl_i)
    else $error("alarm released outside a bus write");
  flag_cause_a: assert property ($fell(int_oe_n_o) |->
    ($past(sensor_pwr_o, 2) || $past(sensor_pwr_o, 3)))
    else $error("alarm raised without a conversion");
  conv_min_a: assert property ($rose(sensor_pwr_o) |=> sensor_pwr_o[*8])
    else $error("conversion too short");
  range_write_a: assert property (!$stable(range_o) |-> !scl_i)
    else $error("range changed outside a bus write");
  ack_edge_a: assert property (!$stable(sda_oe_n_o) |-> !scl_i)
    else $error("data pin changed while clock high");
  pwr_start_a: assert property ($rose(sensor_pwr_o) |-> !scl_i)
    else $error("sensor powered without a bus write");
  cover property ($fell(int_oe_n_o));
  cover property ($rose(int_oe_n_o));
  cover property ($fell(sensor_pwr_o));
endmodule : alsc_monitor

bind alsc_top alsc_monitor #(.CYC16(CYC16)) mon (.ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .int_o(int_o), .int_oe_n_o(int_oe_n_o),
  .adc_sample_i(adc_sample_i), .range_o(range_o),
  .sensor_pwr_o(sensor_pwr_o));

// ---- testbench/alsc_host.sv ----
// serial bus host model with pulled-up data line
`timescale 1ns/100ps
module alsc_host
  import alsc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sda_oe_n_i,
  output logic scl_o,
  output logic sda_o
);
  logic drv = 1'b1;
  assign sda_o = drv & sda_oe_n_i;
  initial scl_o = 1'b1;
  task automatic wt();
    repeat (4) @(negedge ref_clk_i);
  endtask : wt
  task automatic start_bit();
    wt();
    drv = 1'b1;
    wt();
    scl_o = 1'b1;
    wt();
    drv = 1'b0;
    wt();
    scl_o = 1'b0;
  endtask : start_bit
  task automatic stop_bit();
    wt();
    drv = 1'b0;
    wt();
    scl_o = 1'b1;
    wt();
    drv = 1'b1;
    wt();
  endtask : stop_bit
  task automatic byte_io(input logic [7:0] d, input logic m,
                         output logic [7:0] q, output logic a);
    for (int i = 8; i >= 0; i--) begin
      wt();
      drv = (i == 0) ? m : d[i - 1];
      wt();
      scl_o = 1'b1;
      wt();
      if (i == 0) a = sda_o;
      else q[i - 1] = sda_o;
      scl_o = 1'b0;
    end
  endtask : byte_io
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    logic a;
    start_bit();
    byte_io({I2C_ADDR, 1'b0}, 1'b1, q, a);
    byte_io(p, 1'b1, q, a);
    byte_io(d, 1'b1, q, a);
    stop_bit();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] p, output logic [7:0] q);
    logic a;
    start_bit();
    byte_io({I2C_ADDR, 1'b0}, 1'b1, q, a);
    byte_io(p, 1'b1, q, a);
    stop_bit();
    start_bit();
    byte_io({I2C_ADDR, 1'b1}, 1'b1, q, a);
    byte_io(8'hff, 1'b1, q, a);
    stop_bit();
  endtask : read_reg
endmodule : alsc_host

// ---- testbench/testbench.sv ----
// self-checking bench for the light sensor controller
`timescale 1ns/100ps
module testbench
  import alsc_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [15:0] adc_sample_i = 16'h0000;
  logic scl, sda, sda_o, sda_oe_n_o, int_o, int_oe_n_o, sensor_pwr_o;
  logic [1:0] range_o;
  logic [7:0] q;
  logic a;
  int fails = 0;
  int tests_run = 0;
  localparam int CYC_TB = 400;
  alsc_top #(.CYC16(CYC_TB)) uut (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .int_o(int_o), .int_oe_n_o(int_oe_n_o), .adc_sample_i(adc_sample_i),
    .range_o(range_o), .sensor_pwr_o(sensor_pwr_o));
  alsc_host host (.ref_clk_i(ref_clk_i), .sda_oe_n_i(sda_oe_n_o),
    .scl_o(scl), .sda_o(sda));
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_range();
    for (int r = 0; r < 4; r++) begin
      host.write_reg(REG_CTRL, 8'(r));
      chk(16'(range_o), 16'(r));
      host.read_reg(REG_CTRL, q);
      chk(16'(q), 16'(r));
    end
  endtask : t_range
  task automatic t_oneshot();
    int n;
    int len;
    adc_sample_i = 16'hbeef;
    for (int r = 0; r < 4; r++) begin
      len = CYC_TB >> (4 * r);
      if (len < MIN_CYC) begin
        len = MIN_CYC;
      end
      host.write_reg(REG_CTRL, 8'(r << CTRL_RES_LSB));
      host.write_reg(REG_CMD, 8'h01);
      chk(16'(sensor_pwr_o), 16'h0001);
      // host returns 28 clocks after the write lands
      n = 0;
      while (sensor_pwr_o !== 1'b0 && n < 2000) begin
        @(negedge ref_clk_i);
        n++;
      end
      chk(16'(n), 16'(len - 26));
      repeat (300) @(negedge ref_clk_i);
      chk(16'(sensor_pwr_o), 16'h0000);
      host.read_reg(REG_DATA_LSB, q);
      chk(16'(q), (16'hbeef >> (4 * r)) & 16'h00ff);
      host.read_reg(REG_DATA_MSB, q);
      chk(16'(q), 16'hbeef >> (4 * r + 8));
    end
  endtask : t_oneshot
  task automatic t_alarm();
    host.write_reg(REG_CTRL, 8'h00);
    host.write_reg(REG_THR_LSB, 8'h00);
    host.write_reg(REG_THR_MSB, 8'h01);
    adc_sample_i = 16'h0200;
    host.write_reg(REG_CMD, 8'h02);
    for (int i = 0; i < 2000 && int_oe_n_o !== 1'b0; i++)
      @(negedge ref_clk_i);
    chk(16'(int_oe_n_o), 16'h0000);
    chk(16'(int_o), 16'h0000);
    adc_sample_i = 16'h0000;
    repeat (1000) @(negedge ref_clk_i);
    chk(16'(int_oe_n_o), 16'h0000);
    chk(16'(sensor_pwr_o), 16'h0001);
    host.read_reg(REG_DATA_MSB, q);
    chk(16'(q), 16'h0000);
    host.read_reg(REG_CMD, q);
    chk(16'(q[CMD_FLAG_BIT]), 16'h0001);
    host.write_reg(REG_CMD, 8'h02);
    chk(16'(int_oe_n_o), 16'h0001);
    host.read_reg(REG_CMD, q);
    chk(16'(q), 16'h0002);
  endtask : t_alarm
  task automatic t_pd();
    host.write_reg(REG_CMD, 8'h03);
    host.read_reg(REG_CMD, q);
    chk(16'(q), 16'h0000);
    host.write_reg(REG_CMD, 8'h00);
    repeat (4) @(negedge ref_clk_i);
    chk(16'(sensor_pwr_o), 16'h0000);
    host.start_bit();
    host.byte_io(8'h8c, 1'b1, q, a);
    host.stop_bit();
    chk(16'(a), 16'h0001);
  endtask : t_pd
  initial begin
    #2_000_000;
    fails++;
    test_done();
  end
  initial begin
    repeat (16) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    t_range();
    t_oneshot();
    t_alarm();
    t_pd();
    test_done();
  end
endmodule : testbench
